//--- hdl/vjc_ctrl.sv
// Top of the virtual scan controller: takes one command at a time and
// turns it into instruction and data scans on the test port pins.
// Assumes node addresses, capture values and the common field width and
// chain length come from the compiled design's report.
`timescale 1ns/1ps
module vjc_ctrl
    import vjc_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_cmd_valid,
    output logic                   o_cmd_ready,
    input  wire vjc_op_t           i_cmd_op,
    input  wire logic [ADDR_W-1:0] i_node_addr,
    input  wire logic [VAL_W-1:0]  i_vir_value,
    input  wire logic [VAL_W-1:0]  i_rb_cmd,
    input  wire logic [VAL_W-1:0]  i_ovr_cmd,
    input  wire logic [FW_W-1:0]   i_field_w,
    input  wire logic [LEN_W-1:0]  i_virtual_ir_path_instruction_len,
    input  wire logic [LEN_W-1:0]  i_dr_len,
    input  wire logic [SCAN_W-1:0] i_dr_data,
    output logic                   o_rsp_valid,
    output logic [SCAN_W-1:0]      o_rsp_data,
    output logic                   o_tck,
    output logic                   o_tms,
    output logic                   o_tdi,
    input  wire logic              i_tdo
);
    // The reset walk is first so that an all-zero reset starts one.
    typedef enum logic [2:0] {
        C_RST,
        C_IDLE,
        C_IR,
        C_DR1,
        C_DR2
    } vjc_cstate_t;

    typedef struct packed {
        vjc_cstate_t       state;
        logic              issued;
        logic              booted;
        vjc_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [VAL_W-1:0]  val;
        logic [VAL_W-1:0]  hub_cmd;
        logic [FW_W-1:0]   fw;
        logic [LEN_W-1:0]  ulen;
        logic [LEN_W-1:0]  dlen;
        logic [SCAN_W-1:0] ddat;
        logic [ADDR_W-1:0] act_addr;
        logic              act_ok;
        logic              rsp_valid;
        logic [SCAN_W-1:0] rsp_data;
    } vjc_ctrl_st_t;

    vjc_ctrl_st_t      st_reg;
    vjc_ctrl_st_t      st_next;
    logic              tdo_lvl;
    logic              scan_req;
    vjc_scan_t         scan_mode;
    logic [LEN_W-1:0]  scan_len;
    logic [SCAN_W-1:0] scan_data;

    vjc_scan_if sif ();

    vjc_pin_sync u_tdo_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_pin     (i_tdo),
        .o_level   (tdo_lvl)
    );

    vjc_tap_engine u_eng (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_tdo     (tdo_lvl),
        .sif       (sif),
        .o_tck     (o_tck),
        .o_tms     (o_tms),
        .o_tdi     (o_tdi)
    );

    always_comb begin
        st_next = st_reg;
        st_next.rsp_valid = 1'b0;
        scan_mode = VJC_SCAN_RST;
        scan_len = '0;
        scan_data = '0;
        unique case (st_reg.state)
            C_RST: begin
                scan_mode = VJC_SCAN_RST;
            end
            C_IDLE: begin
                if (i_cmd_valid) begin
                    st_next.op = i_cmd_op;
                    st_next.addr = i_node_addr;
                    st_next.val = i_vir_value;
                    // A hub that may be on another node needs the override.
                    if (!st_reg.act_ok || st_reg.act_addr != i_node_addr) begin
                        st_next.hub_cmd = i_ovr_cmd;
                    end else begin
                        st_next.hub_cmd = i_rb_cmd;
                    end
                    st_next.fw = vjc_field_w(i_field_w);
                    st_next.ulen = i_virtual_ir_path_instruction_len;
                    st_next.dlen = i_dr_len;
                    st_next.ddat = i_dr_data;
                    if (i_cmd_op == VJC_OP_RST) begin
                        st_next.state = C_RST;
                    end else begin
                        st_next.state = C_IR;
                    end
                end
            end
            C_IR: begin
                scan_mode = VJC_SCAN_IR;
                scan_len = LEN_W'(IR_LEN);
                if (st_reg.op == VJC_OP_VDR) begin
                    scan_data[IR_LEN-1:0] = OP_VDR_PATH;
                end else begin
                    scan_data[IR_LEN-1:0] = OP_VIR_PATH;
                end
            end
            C_DR1: begin
                // The hub takes this scan as the address cycle.
                scan_mode = VJC_SCAN_DR;
                scan_len = st_reg.ulen;
                scan_data = vjc_payload(HUB_ADDR, st_reg.hub_cmd,
                                        st_reg.fw);
            end
            C_DR2: begin
                scan_mode = VJC_SCAN_DR;
                if (st_reg.op == VJC_OP_VDR) begin
                    scan_len = st_reg.dlen;
                    scan_data = st_reg.ddat;
                end else begin
                    scan_len = st_reg.ulen;
                    scan_data = vjc_payload(st_reg.addr, st_reg.val,
                                            st_reg.fw);
                end
            end
        endcase
        scan_req = st_reg.state != C_IDLE && !st_reg.issued && !sif.busy;
        if (scan_req) begin
            st_next.issued = 1'b1;
        end
        if (sif.done) begin
            st_next.issued = 1'b0;
            unique case (st_reg.state)
                C_RST: begin
                    // The hub's node selection is unknown after a reset.
                    st_next.state = C_IDLE;
                    st_next.rsp_valid = st_reg.booted;
                    st_next.booted = 1'b1;
                    st_next.act_ok = 1'b0;
                end
                C_IR: begin
                    if (st_reg.op == VJC_OP_VIR_RB) begin
                        st_next.state = C_DR1;
                    end else begin
                        st_next.state = C_DR2;
                    end
                end
                C_DR1: begin
                    st_next.state = C_DR2;
                end
                C_DR2: begin
                    st_next.state = C_IDLE;
                    st_next.rsp_valid = 1'b1;
                    if (st_reg.op == VJC_OP_VDR) begin
                        st_next.rsp_data = sif.cap;
                    end else begin
                        // Only the value field is returned; bits above it are cleared.
                        st_next.rsp_data = sif.cap & vjc_mask(st_reg.fw);
                        st_next.act_addr = st_reg.addr;
                        st_next.act_ok = 1'b1;
                    end
                end
                C_IDLE: begin
                    st_next.state = C_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sif.req     = scan_req;
    assign sif.mode    = scan_mode;
    assign sif.len     = scan_len;
    assign sif.data    = scan_data;
    assign o_cmd_ready = st_reg.state == C_IDLE;
    assign o_rsp_valid = st_reg.rsp_valid;
    assign o_rsp_data  = st_reg.rsp_data;

    // Checks run on the reference clock; the test clock is only a pin here.
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    chk_ir_scan_length: assert property (
        scan_req && scan_mode == VJC_SCAN_IR |-> scan_len == LEN_W'(IR_LEN))
        else $error("Instruction scan length is wrong.");

    chk_ir_path_codes: assert property (
        scan_req && scan_mode == VJC_SCAN_IR
        |-> scan_data[IR_LEN-1:0] == ((st_reg.op == VJC_OP_VDR)
            ? OP_VDR_PATH : OP_VIR_PATH))
        else $error("Instruction code does not match the command.");

    chk_vir_after_ir: assert property (
        $changed(st_reg.state) && st_reg.state == C_DR2
        && st_reg.op == VJC_OP_VIR |-> $past(st_reg.state) == C_IR)
        else $error("Instruction payload scan not preceded by code load.");

    chk_vir_payload: assert property (
        scan_req && st_reg.state == C_DR2 && st_reg.op != VJC_OP_VDR
        |-> (scan_data >> st_reg.fw) == SCAN_W'(st_reg.addr))
        else $error("Node address not above the value field.");

    chk_common_length: assert property (
        scan_req && scan_mode == VJC_SCAN_DR && st_reg.op != VJC_OP_VDR
        |-> scan_len == st_reg.ulen)
        else $error("Instruction-path scan length differs.");

    chk_field_floor: assert property (
        st_reg.state inside {C_IR, C_DR1, C_DR2} |-> st_reg.fw >= HUB_VIR_FW)
        else $error("Value field narrower than four bits.");

    chk_vdr_plain_data: assert property (
        scan_req && st_reg.state == C_DR2 && st_reg.op == VJC_OP_VDR
        |-> scan_len == st_reg.dlen && scan_data == st_reg.ddat)
        else $error("Data scan altered the caller data.");

    chk_readback_order: assert property (
        sif.done && st_reg.state == C_IR && st_reg.op == VJC_OP_VIR_RB
        |=> st_reg.state == C_DR1 ##1 st_reg.state == C_DR1)
        else $error("Readback did not begin with the hub scan.");

    chk_override_used: assert property (
        o_cmd_ready && i_cmd_valid
        && (!st_reg.act_ok || st_reg.act_addr != i_node_addr)
        |=> st_reg.hub_cmd == $past(i_ovr_cmd))
        else $error("Override missing for a non-active node.");

    chk_hub_address_cycle: assert property (
        scan_req && st_reg.state == C_DR1
        |-> (scan_data >> st_reg.fw) == SCAN_W'(HUB_ADDR)
            && scan_len == st_reg.ulen)
        else $error("Readback did not open with the hub address cycle.");

    chk_second_scan: assert property (
        sif.done && st_reg.state == C_DR1 |=> st_reg.state == C_DR2)
        else $error("Readback did not follow with the node scan.");

    chk_vdr_after_ir: assert property (
        $changed(st_reg.state) && st_reg.state == C_DR2
        && st_reg.op == VJC_OP_VDR |-> $past(st_reg.state) == C_IR)
        else $error("Data scan not preceded by the data path code.");

    chk_hub_cmd_value: assert property (
        o_cmd_ready && i_cmd_valid && st_reg.act_ok
        && st_reg.act_addr == i_node_addr
        |=> st_reg.hub_cmd == $past(i_rb_cmd))
        else $error("Readback command missing for the active node.");

    chk_reset_forgets_node: assert property (
        sif.done && st_reg.state == C_RST
        |=> st_reg.state == C_IDLE && !st_reg.act_ok)
        else $error("Active node survived a port reset.");

    // Each cover marks one command kind running through to its end.

    cov_vir_write: cover property (
        st_reg.state == C_DR2 && sif.done && st_reg.op == VJC_OP_VIR);
    cov_vir_readback: cover property (
        st_reg.state == C_DR2 && sif.done && st_reg.op == VJC_OP_VIR_RB);
    cov_vdr_access: cover property (
        st_reg.state == C_DR2 && sif.done && st_reg.op == VJC_OP_VDR);
    cov_port_reset: cover property (
        st_reg.state == C_RST && sif.done && st_reg.booted);
endmodule : vjc_ctrl

//--- hdl/vjc_pin_sync.sv
// Three-stage synchroniser for the returning test data pin.
// Assumes the pin is asynchronous to the reference clock.
`timescale 1ns/1ps
module vjc_pin_sync (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_pin,
    output logic      o_level
);
    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } vjc_sync_st_t;

    vjc_sync_st_t st_reg;
    vjc_sync_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.stage = {st_reg.stage[1:0], i_pin};
        // The first stage is never compared, only passed on.
        if (st_reg.stage[1] == st_reg.stage[2]) begin
            st_next.level = st_reg.stage[2];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_level = st_reg.level;
endmodule : vjc_pin_sync

//--- hdl/vjc_pkg.sv
// Constants, types and payload helpers of the virtual scan controller.
// Assumes one target test port and a 250 MHz reference clock.
package vjc_pkg;
    localparam int REF_HZ     = 250_000_000;
    localparam int TCK_MAX_HZ = 10_000_000;
    // A least half period, so the division rounds up.
    localparam int HALF_CYC   = (REF_HZ + 2 * TCK_MAX_HZ - 1)
                                / (2 * TCK_MAX_HZ);
    localparam int DIV_W      = 4;
    localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CYC - 1);

    localparam int IR_LEN  = 10;
    localparam int SCAN_W  = 64;
    localparam int LEN_W   = 7;
    localparam int ADDR_W  = 16;
    localparam int VAL_W   = 16;
    localparam int FW_W    = 5;
    localparam int HUB_VIR_W   = 4;
    localparam int RST_TMS_CYC = 5;

    localparam logic [IR_LEN-1:0] OP_VIR_PATH = 10'h00e;
    localparam logic [IR_LEN-1:0] OP_VDR_PATH = 10'h00c;
    localparam logic [ADDR_W-1:0] HUB_ADDR    = 16'h0000;
    localparam logic [FW_W-1:0]   HUB_VIR_FW  = FW_W'(HUB_VIR_W);

    // Test-mode-select prefixes from run-test/idle, sent first bit first.
    localparam logic [7:0] PRE_DR_PAT  = 8'h01;
    localparam logic [7:0] PRE_DR_N    = 8'h03;
    localparam logic [7:0] PRE_IR_PAT  = 8'h03;
    localparam logic [7:0] PRE_IR_N    = 8'h04;
    localparam logic [7:0] PRE_RST_PAT = 8'((1 << RST_TMS_CYC) - 1);
    localparam logic [7:0] PRE_RST_N   = 8'(RST_TMS_CYC + 1);
    localparam logic [7:0] RST_HI_N    = 8'(RST_TMS_CYC);
    localparam logic [7:0] POST_N      = 8'h02;

    typedef enum logic [1:0] {
        VJC_SCAN_RST,
        VJC_SCAN_IR,
        VJC_SCAN_DR
    } vjc_scan_t;

    typedef enum logic [1:0] {
        VJC_OP_VIR,
        VJC_OP_VIR_RB,
        VJC_OP_VDR,
        VJC_OP_RST
    } vjc_op_t;

    function automatic logic [SCAN_W-1:0] vjc_mask(input logic [FW_W-1:0] w);
        return ~({SCAN_W{1'b1}} << w);
    endfunction : vjc_mask

    function automatic logic [FW_W-1:0] vjc_field_w(input logic [FW_W-1:0] w);
        return (w < HUB_VIR_FW) ? HUB_VIR_FW : w;
    endfunction : vjc_field_w

    function automatic logic [SCAN_W-1:0] vjc_payload(
        input logic [ADDR_W-1:0] addr,
        input logic [VAL_W-1:0]  val,
        input logic [FW_W-1:0]   fw
    );
        logic [SCAN_W-1:0] a;
        logic [SCAN_W-1:0] v;
        a = {{(SCAN_W-ADDR_W){1'b0}}, addr};
        v = {{(SCAN_W-VAL_W){1'b0}}, val};
        return (a << fw) | (v & vjc_mask(fw));
    endfunction : vjc_payload
endpackage : vjc_pkg

//--- hdl/vjc_scan_if.sv
// Scan request and result between the sequencer and the pin engine.
// Assumes both ends run on the reference clock.
`timescale 1ns/1ps
interface vjc_scan_if;
    import vjc_pkg::*;
    logic              req;
    vjc_scan_t         mode;
    logic [LEN_W-1:0]  len;
    logic [SCAN_W-1:0] data;
    logic              busy;
    logic              done;
    logic [SCAN_W-1:0] cap;
    modport ctrl (output req, mode, len, data, input busy, done, cap);
    modport eng  (input req, mode, len, data, output busy, done, cap);
endinterface : vjc_scan_if

//--- hdl/vjc_tap_engine.sv
// Pin engine: divides the reference clock into the test clock and walks
// the test port from run-test/idle through one scan and back.
// Assumes the target samples on the rising and updates on the falling edge.
`timescale 1ns/1ps
module vjc_tap_engine
    import vjc_pkg::*;
(
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_tdo,
    vjc_scan_if.eng   sif,
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi
);
    typedef struct packed {
        logic              act;
        logic              tck;
        logic [DIV_W-1:0]  div;
        logic [7:0]        idx;
        logic [7:0]        pre_n;
        logic [7:0]        pre_pat;
        logic [LEN_W-1:0]  len;
        logic [SCAN_W-1:0] dat;
        logic [SCAN_W-1:0] cap;
        logic              tms;
        logic              tdi;
        logic              done;
    } vjc_eng_st_t;

    vjc_eng_st_t st_reg;
    vjc_eng_st_t st_next;

    // Returns {tms, tdi} for test clock cycle i of the scan.
    function automatic logic [1:0] bit_at(input vjc_eng_st_t s,
                                          input logic [7:0] i);
        logic [7:0] k;
        logic [7:0] n;
        k = i - s.pre_n;
        n = {1'b0, s.len};
        if (i < s.pre_n) begin
            return {s.pre_pat[i[2:0]], 1'b0};
        end
        if (k < n) begin
            return {k == n - 8'h01, s.dat[k[5:0]]};
        end
        return {k == n, 1'b0};
    endfunction : bit_at

    always_comb begin
        logic [7:0] k;
        logic [7:0] total;
        k = st_reg.idx - st_reg.pre_n;
        total = st_reg.pre_n + ((st_reg.len != '0)
                ? ({1'b0, st_reg.len} + POST_N) : 8'h00);
        st_next = st_reg;
        st_next.done = 1'b0;
        if (!st_reg.act) begin
            if (sif.req) begin
                st_next.len = sif.len;
                st_next.dat = sif.data;
                unique case (sif.mode)
                    VJC_SCAN_IR: begin
                        st_next.pre_n = PRE_IR_N;
                        st_next.pre_pat = PRE_IR_PAT;
                    end
                    VJC_SCAN_DR: begin
                        st_next.pre_n = PRE_DR_N;
                        st_next.pre_pat = PRE_DR_PAT;
                    end
                    default: begin
                        st_next.pre_n = PRE_RST_N;
                        st_next.pre_pat = PRE_RST_PAT;
                        st_next.len = '0;
                    end
                endcase
                st_next.act = 1'b1;
                st_next.idx = '0;
                st_next.div = '0;
                st_next.cap = '0;
                {st_next.tms, st_next.tdi} = bit_at(st_next, 8'h00);
            end
        end else if (st_reg.div == HALF_LAST) begin
            st_next.div = '0;
            st_next.tck = ~st_reg.tck;
            if (!st_reg.tck) begin
                if (st_reg.idx >= st_reg.pre_n && k < {1'b0, st_reg.len}) begin
                    st_next.cap[k[5:0]] = i_tdo;
                end
            end else if (st_reg.idx + 8'h01 == total) begin
                // Leave the port parked in run-test/idle with the clock low.
                st_next.act = 1'b0;
                st_next.done = 1'b1;
                st_next.tms = 1'b0;
                st_next.tdi = 1'b0;
            end else begin
                st_next.idx = st_reg.idx + 8'h01;
                {st_next.tms, st_next.tdi} = bit_at(st_reg, st_next.idx);
            end
        end else begin
            st_next.div = st_reg.div + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sif.busy = st_reg.act;
    assign sif.done = st_reg.done;
    assign sif.cap  = st_reg.cap;
    assign o_tck    = st_reg.tck;
    assign o_tms    = st_reg.tms;
    assign o_tdi    = st_reg.tdi;

    chk_reset_tms_high: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        st_reg.act && st_reg.pre_n == PRE_RST_N && st_reg.idx < RST_HI_N
        |-> st_reg.tms && st_reg.len == '0)
        else $error("Reset walk dropped mode select too early.");
endmodule : vjc_tap_engine

//--- tb/tb_vjc_ctrl.sv
// Self-checking bench of the virtual scan controller.
// Assumes the device model logs every completed scan in order.
`timescale 1ns/1ps
module tb_vjc_ctrl;
    import vjc_pkg::*;
    localparam logic [72:0] RST_MARK = {1'b1, 8'hff, 64'h0};
    logic              i_ref_clk   = 1'b0;
    logic              i_rst_n     = 1'b0;
    logic              i_cmd_valid = 1'b0;
    vjc_op_t           i_cmd_op    = VJC_OP_VIR;
    logic [ADDR_W-1:0] i_node_addr = 16'h0;
    logic [VAL_W-1:0]  i_vir_value = 16'h0;
    logic [VAL_W-1:0]  i_rb_cmd    = 16'h0003;
    logic [VAL_W-1:0]  i_ovr_cmd   = 16'h0001;
    logic [FW_W-1:0]   i_field_w   = 5'h03;
    logic [LEN_W-1:0]  i_virtual_ir_path_instruction_len = 7'h08;
    logic [LEN_W-1:0]  i_dr_len    = 7'h08;
    logic [SCAN_W-1:0] i_dr_data   = 64'h0;
    logic              o_cmd_ready, o_rsp_valid, o_tck, o_tms, o_tdi, i_tdo;
    logic [SCAN_W-1:0] o_rsp_data;
    int                error_cnt    = 0;
    int                total_checks = 0;

    always #2 i_ref_clk = ~i_ref_clk;

    vjc_ctrl vjc_ctrl_inst (.i_ref_clk, .i_rst_n, .i_cmd_valid, .o_cmd_ready,
        .i_cmd_op, .i_node_addr, .i_vir_value, .i_rb_cmd, .i_ovr_cmd,
        .i_field_w, .i_virtual_ir_path_instruction_len, .i_dr_len, .i_dr_data, .o_rsp_valid,
        .o_rsp_data, .o_tck, .o_tms, .o_tdi, .i_tdo);
    vjc_dev_model #(.FIELD(3)) vjc_dev_model_inst (.i_tck(o_tck),
        .i_tms(o_tms), .i_tdi(o_tdi), .o_tdo(i_tdo));

    task automatic results;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    task automatic check(input string what, input logic [72:0] seen,
                         input logic [72:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic scan(input logic [72:0] exp);
        logic [72:0] s;
        s = '1;
        if (vjc_dev_model_inst.log_q.size() > 0) begin
            s = vjc_dev_model_inst.log_q.pop_front();
        end
        check("scan", s, exp);
    endtask : scan

    task automatic run(input vjc_op_t op, input logic [15:0] a,
                       input logic [15:0] v, input logic [6:0] n,
                       input logic [63:0] d);
        int t;
        @(negedge i_ref_clk);
        for (t = 0; t < 500 && o_cmd_ready !== 1'b1; t++) @(negedge i_ref_clk);
        check("cmd_ready", 73'(o_cmd_ready), 73'h1);
        @(posedge i_ref_clk);
        i_cmd_valid <= 1'b1;
        i_cmd_op    <= op;
        i_node_addr <= a;
        i_vir_value <= v;
        i_dr_len    <= n;
        i_dr_data   <= d;
        @(posedge i_ref_clk);
        i_cmd_valid <= 1'b0;
        @(negedge i_ref_clk);
        check("cmd_taken", 73'(o_cmd_ready), 73'h0);
        for (t = 0; t < 8000 && o_rsp_valid !== 1'b1; t++) @(negedge i_ref_clk);
        check("rsp_valid", 73'(o_rsp_valid), 73'h1);
    endtask : run

    // A three-bit node still gets the four-bit field, address above it.
    task automatic t_vir_write;
        run(VJC_OP_VIR, 16'h0002, 16'h0005, 7'h08, 64'h0);
        scan({1'b1, 8'h0a, 64'h00e});
        scan({1'b0, 8'h08, 64'h25});
    endtask : t_vir_write

    task automatic t_readback(input logic [15:0] a, input logic [15:0] v,
                              input logic [63:0] hub, input logic [63:0] old);
        run(VJC_OP_VIR_RB, a, v, 7'h08, 64'h0);
        scan({1'b1, 8'h0a, 64'h00e});
        scan({1'b0, 8'h08, hub});
        scan({1'b0, 8'h08, 64'((a << 4) | v)});
        check("rb_data", 73'(o_rsp_data), 73'(old));
    endtask : t_readback

    task automatic t_vdr(input logic [6:0] n, input logic [63:0] d);
        logic [63:0] m;
        m = (n == 7'h40) ? '1 : ((64'h1 << n) - 64'h1);
        run(VJC_OP_VDR, 16'h0, 16'h0, n, d);
        scan({1'b1, 8'h0a, 64'h00c});
        scan({1'b0, 8'(n), d & m});
        check("vdr_data", 73'(o_rsp_data & m),
              73'(vjc_dev_model_inst.VDR_PAT & m));
    endtask : t_vdr

    task automatic t_reset;
        run(VJC_OP_RST, 16'h0, 16'h0, 7'h08, 64'h0);
        scan(RST_MARK);
        // No node is active after a port reset, so the override is used.
        t_readback(16'h0003, 16'h0004, 64'h01, 64'h0);
    endtask : t_reset

    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        run(VJC_OP_VIR, 16'h0001, 16'h000f, 7'h08, 64'h0);
        scan(RST_MARK);
        scan({1'b1, 8'h0a, 64'h00e});
        scan({1'b0, 8'h08, 64'h1f});
        t_vir_write();
        t_readback(16'h0002, 16'h0006, 64'h03, 64'h5);
        t_readback(16'h0003, 16'h0009, 64'h01, 64'h6);
        t_vdr(7'h40, 64'hf0e1_d2c3_b4a5_9687);
        t_vdr(7'h01, 64'h1);
        t_reset();
        results();
    end

    initial begin
        #200000;
        error_cnt++;
        results();
    end
endmodule : tb_vjc_ctrl

//--- tb/vjc_dev_model.sv
// Target device model: test port state machine, ten-bit instruction
// register, one data chain per path, and a hub holding the active node.
// Assumes it sees only the controller's pins; the test clock idles low.
`timescale 1ns/1ps
module vjc_dev_model
    import vjc_pkg::*;
#(
    parameter int          FIELD   = 4,
    parameter logic [63:0] VDR_PAT = 64'h8c3a_5f10_e7b2_96d4
) (
    input  wire logic i_tck,
    input  wire logic i_tms,
    input  wire logic i_tdi,
    output logic      o_tdo
);
    localparam int FW = (FIELD < HUB_VIR_W) ? HUB_VIR_W : FIELD;
    logic [3:0]        st      = 4'h1;
    logic [63:0]       sr      = 64'h0;
    logic [63:0]       cap     = 64'h0;
    logic [IR_LEN-1:0] ir      = 10'h3ff;
    logic [VAL_W-1:0]  vir_act = 16'h0;
    logic              armed   = 1'b0;
    int                cnt     = 0;
    int                hi      = 0;
    logic [72:0]       log_q[$];
    wire  [63:0]       pay     = sr >> (64 - cnt);

    function automatic logic [3:0] nxt(input logic [3:0] s, input logic m);
        case (s)
            4'h0: return m ? 4'h0 : 4'h1;
            4'h1, 4'h8, 4'hf: return m ? 4'h2 : 4'h1;
            4'h2: return m ? 4'h9 : 4'h3;
            4'h3, 4'h4: return m ? 4'h5 : 4'h4;
            4'h5: return m ? 4'h8 : 4'h6;
            4'h6: return m ? 4'h7 : 4'h6;
            4'h7: return m ? 4'h8 : 4'h4;
            4'h9: return m ? 4'h0 : 4'ha;
            4'ha, 4'hb: return m ? 4'hc : 4'hb;
            4'hc: return m ? 4'hf : 4'hd;
            4'hd: return m ? 4'he : 4'hd;
            default: return m ? 4'hf : 4'hb;
        endcase
    endfunction : nxt

    always @(posedge i_tck) begin
        hi <= i_tms ? hi + 1 : 0;
        if (st == 4'h0) begin
            // A held-high mode select resets the hub and drops node state.
            armed   <= 1'b0;
            vir_act <= '0;
        end
        if (i_tms && hi == RST_TMS_CYC - 1) begin
            log_q.push_back({1'b1, 8'hff, 64'h0});
        end
        if (st == 4'h3 || st == 4'ha) begin
            cnt <= 0;
            cap <= (st == 4'ha) ? 64'h1 : (ir == OP_VDR_PATH) ? VDR_PAT
                 : armed ? 64'(vir_act) : 64'h0;
        end
        if (st == 4'h4 || st == 4'hb) begin
            sr  <= {i_tdi, sr[63:1]};
            cnt <= cnt + 1;
        end
        if (st == 4'h8 || st == 4'hf) begin
            log_q.push_back({st == 4'hf, 8'(cnt), pay});
        end
        if (st == 4'hf) begin
            ir <= sr[63 -: IR_LEN];
        end
        if (st == 4'h8 && ir == OP_VIR_PATH) begin
            // The hub scan only arms the capture; a node scan updates it.
            armed <= ((pay >> FW) == 64'(HUB_ADDR));
            if ((pay >> FW) != 64'(HUB_ADDR)) begin
                vir_act <= 16'(pay & ~(64'hffff_ffff_ffff_ffff << FW));
            end
        end
        st <= nxt(st, i_tms);
    end

    // A released data pin shows a changing level, never its last bit.
    always @(negedge i_tck) begin
        o_tdo <= (st == 4'h4 || st == 4'hb) ? cap[6'(cnt)] : ~o_tdo;
    end
    initial o_tdo = 1'b0;
endmodule : vjc_dev_model
